// File: rtl/etx_mac_tx.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module etx_mac_tx import etx_pkg::*; #(
	parameter int FIFO_DEPTH = 80
) (
	// clock and reset
	input logic mclk,
	input logic reset_n,
	// apb slave
	input logic [7:0] paddr,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// dma to mac interface
	input logic [7:0] dma_data,
	input logic dma_par,
	input logic dma_last,
	input logic dma_valid,
	output logic dma_ready,
	// mii transmit side
	input logic mii_tx_clk,
	input logic mii_crs,
	input logic mii_col,
	output logic [3:0] mii_txd,
	output logic mii_tx_en
);
	localparam logic [7:0] DEPTH = 8'(FIFO_DEPTH);
	localparam logic [6:0] PTR_LAST = 7'(FIFO_DEPTH - 1);

	etx_state_t st_q;
	logic [CTL_W-1:0] ctrl_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, dma_ready_q, tx_en_q;
	logic [3:0] txd_q;
	logic clk_s1_q, clk_s2_q, clk_s3_q, crs_s1_q, crs_s2_q, col_s1_q, col_s2_q;
	logic [9:0] mem_q [FIFO_DEPTH];
	logic [6:0] wr_q, rd_q, keep_q, rd_d;
	logic [7:0] avail_q, occ_q, avail_d;
	logic tail_last_q;
	logic pop_q, rewind_q, sync_q, done_q, abort_q, coll_q, released_q, phase_q, own_q;
	logic [9:0] cur_q;
	logic [31:0] crc_q;
	logic [3:0] nib_q, jam_q;
	logic [7:0] win_q;
	logic [11:0] byte_q;
	logic [4:0] att_q, gap_q;
	logic [16:0] bo_q;
	logic [10:0] lfsr_q;
	logic sta_done_q, sta_abort_q, sta_coll_q;

	logic tx_edge, push, in_frame, start_ok, gap_ok, fdx, halted, coll_now;
	logic [9:0] head;
	logic [7:0] byte_out;
	logic [11:0] pad_target;
	logic [9:0] bo_mask;
	logic [4:0] att_n, k_lim;
	logic apb_acc, apb_wr, hit_ctrl, hit_stat;
	logic [31:0] stat_w;

	function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] x;
		x = c;
		for (int i = 0; i < 8; i++) begin
			x = (x[0] ^ b[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign dma_ready = dma_ready_q;
	assign mii_txd = txd_q;
	assign mii_tx_en = tx_en_q;

	// transmit clock and mii status sampled through two flops
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			crs_s1_q <= 1'b0;
			crs_s2_q <= 1'b0;
			col_s1_q <= 1'b0;
			col_s2_q <= 1'b0;
		end else begin
			clk_s1_q <= mii_tx_clk;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			crs_s1_q <= mii_crs;
			crs_s2_q <= crs_s1_q;
			col_s1_q <= mii_col;
			col_s2_q <= col_s1_q;
		end
	end

	assign tx_edge = clk_s2_q & ~clk_s3_q;
	assign fdx = ctrl_q[CTL_FDX];
	assign halted = ctrl_q[CTL_TXHALT] | ctrl_q[CTL_HALTIMM] | ctrl_q[CTL_HALTREQ];
	assign push = dma_valid & dma_ready_q;
	assign head = mem_q[rd_q];
	assign in_frame = (st_q == ST_PRE) | (st_q == ST_DATA) | (st_q == ST_PAD) | (st_q == ST_FCS);
	assign gap_ok = (gap_q == GAP_NIBS);
	assign coll_now = tx_edge & in_frame & col_s2_q & ~fdx & (win_q < WIN_NIBS);
	assign byte_out = (st_q == ST_PAD) ? 8'h00 : head[7:0];
	assign pad_target = ctrl_q[CTL_CRCEN] ? (MIN_FRAME - CRC_BYTES) : MIN_FRAME;
	assign att_n = att_q + 5'h01;
	assign k_lim = (att_n < BACKOFF_LIMIT) ? att_n : BACKOFF_LIMIT;
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			bo_mask[i] = (5'(i) < k_lim);
		end
	end

	// start needs enable, no halt, gap, ready mii and queued data
	assign start_ok = ctrl_q[CTL_TXEN] & ~halted & gap_ok & ~col_s2_q & ~(fdx & crs_s2_q)
		& ((avail_q >= START_BYTES) | (tail_last_q & (avail_q != 8'h00)));

	// fifo pointers; the retained start is rewound to on a retry
	always_comb begin
		rd_d = rd_q;
		if (rewind_q) begin
			rd_d = keep_q;
		end else if (pop_q) begin
			rd_d = (rd_q == PTR_LAST) ? 7'h00 : rd_q + 7'h01;
		end
		avail_d = rewind_q ? occ_q + {7'h00, push} : avail_q + {7'h00, push} - {7'h00, pop_q};
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= 7'h00;
			rd_q <= 7'h00;
			keep_q <= 7'h00;
			avail_q <= 8'h00;
			occ_q <= 8'h00;
			tail_last_q <= 1'b0;
			dma_ready_q <= 1'b0;
		end else begin
			if (push) begin
				mem_q[wr_q] <= {dma_par, dma_last, dma_data};
				wr_q <= (wr_q == PTR_LAST) ? 7'h00 : wr_q + 7'h01;
				tail_last_q <= dma_last;
			end
			rd_q <= rd_d;
			avail_q <= avail_d;
			// after release the retained start follows the read side
			if (sync_q | released_q) begin
				keep_q <= rd_d;
				occ_q <= avail_d;
				dma_ready_q <= (avail_d < DEPTH);
			end else begin
				occ_q <= occ_q + {7'h00, push};
				// only the first bytes are accepted until the medium is won
				dma_ready_q <= (occ_q + {7'h00, push} < RETAIN_BYTES);
			end
		end
	end

	// gap timer in nibble times of the transmit clock
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			gap_q <= GAP_NIBS;
			own_q <= 1'b0;
		end else if (tx_en_q) begin
			gap_q <= 5'h00;
			own_q <= 1'b1;
		end else if (tx_edge) begin
			if (!fdx && !own_q && crs_s2_q && (gap_q < GAP_HOLD_NIBS || gap_ok)) begin
				gap_q <= 5'h00;
			end else if (!gap_ok) begin
				gap_q <= gap_q + 5'h01;
			end else begin
				own_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lfsr_q <= LFSR_SEED;
		end else begin
			lfsr_q <= {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]};
		end
	end

	// main transmit machine, stepped on each sampled transmit clock edge except in discard, which steps on the system clock
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_IDLE;
			txd_q <= IDLE_NIB;
			tx_en_q <= 1'b0;
			{pop_q, rewind_q, sync_q, done_q, abort_q, coll_q} <= 6'h00;
			released_q <= 1'b0;
			phase_q <= 1'b0;
			cur_q <= 10'h000;
			crc_q <= CRC_INIT;
			nib_q <= 4'h0;
			jam_q <= 4'h0;
			win_q <= 8'h00;
			byte_q <= 12'h000;
			att_q <= 5'h00;
			bo_q <= 17'h00000;
		end else begin
			{pop_q, rewind_q, sync_q, done_q, abort_q, coll_q} <= 6'h00;
			if (tx_edge && in_frame && win_q != WIN_NIBS) begin
				win_q <= win_q + 8'h01;
			end
			if (coll_now) begin
				// collision inside the window switches to jam
				st_q <= ST_JAM;
				txd_q <= JAM_NIB;
				jam_q <= 4'h1;
				coll_q <= 1'b1;
			end else begin
				case (st_q)
					ST_IDLE: begin
						if (tx_edge) begin
							txd_q <= IDLE_NIB;
							tx_en_q <= 1'b0;
							if (start_ok) begin
								st_q <= ST_PRE;
								txd_q <= PRE_NIB;
								tx_en_q <= 1'b1;
								nib_q <= 4'h1;
								win_q <= 8'h01;
								byte_q <= 12'h000;
								phase_q <= 1'b0;
								cur_q <= 10'h000;
								crc_q <= CRC_INIT;
							end
						end
					end
					ST_PRE: begin
						if (tx_edge) begin
							txd_q <= (nib_q == PRE_LAST) ? SFD_NIB : PRE_NIB;
							nib_q <= nib_q + 4'h1;
							if (nib_q == PRE_LAST) begin
								st_q <= ST_DATA;
							end
						end
					end
					ST_DATA, ST_PAD: begin
						if (tx_edge && !phase_q) begin
							if (st_q == ST_DATA && avail_q == 8'h00) begin
								tx_en_q <= 1'b0;
								txd_q <= IDLE_NIB;
								abort_q <= 1'b1;
								st_q <= ST_DISCARD;
							end else if (st_q == ST_DATA && !(head[PAR_BIT] ^ (^head[7:0]))) begin
								// odd parity over data and parity bit; end marker not covered
								pop_q <= 1'b1;
								tx_en_q <= 1'b0;
								txd_q <= IDLE_NIB;
								abort_q <= 1'b1;
								released_q <= 1'b0;
								sync_q <= head[LAST_BIT];
								st_q <= head[LAST_BIT] ? ST_IDLE : ST_DISCARD;
								att_q <= 5'h00;
							end else begin
								// bytes pass in queue order, pad is zero, both feed crc
								pop_q <= (st_q == ST_DATA);
								if (st_q == ST_DATA) begin
									cur_q <= head;
								end
								txd_q <= byte_out[3:0];
								crc_q <= crc_next(crc_q, byte_out);
								phase_q <= 1'b1;
							end
						end else if (tx_edge) begin
							txd_q <= (st_q == ST_PAD) ? IDLE_NIB : cur_q[7:4];
							byte_q <= byte_q + 12'h001;
							phase_q <= 1'b0;
							// release once the first bytes left cleanly
							if (byte_q + 12'h001 == RELEASE_BYTES) begin
								released_q <= 1'b1;
							end
							if (cur_q[LAST_BIT]) begin
								// pad to the minimum unless short mode, crc if enabled
								if (!ctrl_q[CTL_SHORT] && byte_q + 12'h001 < pad_target) begin
									st_q <= ST_PAD;
								end else if (ctrl_q[CTL_CRCEN]) begin
									st_q <= ST_FCS;
									nib_q <= 4'h0;
								end else begin
									st_q <= ST_IDLE;
									done_q <= 1'b1;
									sync_q <= 1'b1;
									released_q <= 1'b0;
									att_q <= 5'h00;
								end
							end
						end
					end
					ST_FCS: begin
						if (tx_edge) begin
							txd_q <= ~crc_q[3:0];
							crc_q <= {4'h0, crc_q[31:4]};
							nib_q <= nib_q + 4'h1;
							if (nib_q == FCS_LAST) begin
								st_q <= ST_IDLE;
								done_q <= 1'b1;
								sync_q <= 1'b1;
								released_q <= 1'b0;
								att_q <= 5'h00;
							end
						end
					end
					ST_JAM: begin
						if (tx_edge) begin
							if (jam_q == JAM_NIBS) begin
								tx_en_q <= 1'b0;
								txd_q <= IDLE_NIB;
								if (released_q || att_q == MAX_COLL) begin
									// no retry past the limit or after release
									abort_q <= 1'b1;
									att_q <= 5'h00;
									released_q <= 1'b0;
									sync_q <= cur_q[LAST_BIT];
									st_q <= cur_q[LAST_BIT] ? ST_IDLE : ST_DISCARD;
								end else begin
									// back-off of r slots, r from the low k bits
									att_q <= att_n;
									bo_q <= 17'(lfsr_q[9:0] & bo_mask) * SLOT_NIBS;
									rewind_q <= 1'b1;
									st_q <= ST_BACKOFF;
								end
							end else begin
								txd_q <= JAM_NIB;
								jam_q <= jam_q + 4'h1;
							end
						end
					end
					ST_BACKOFF: begin
						if (tx_edge) begin
							if (bo_q == 17'h00000) begin
								st_q <= ST_IDLE;
							end else begin
								bo_q <= bo_q - 17'h00001;
							end
						end
					end
					ST_DISCARD: begin
						// drop the rest of the abandoned frame, one byte per two cycles
						if (!pop_q && avail_q != 8'h00) begin
							pop_q <= 1'b1;
							if (head[LAST_BIT]) begin
								st_q <= ST_IDLE;
								sync_q <= 1'b1;
								released_q <= 1'b0;
								att_q <= 5'h00;
							end
						end
					end
					default: begin
						st_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// apb slave: one wait state, registered answer
	assign apb_acc = psel & penable & ~pready_q;
	assign apb_wr = psel & penable & pready_q & pwrite;
	assign hit_ctrl = (paddr == REG_CTRL);
	assign hit_stat = (paddr == REG_STAT);
	always_comb begin
		stat_w = 32'h00000000;
		stat_w[STA_DONE] = sta_done_q;
		stat_w[STA_ABORT] = sta_abort_q;
		stat_w[STA_COLL] = sta_coll_q;
		stat_w[STA_ATT_LSB +: 5] = att_q;
		stat_w[STA_BUSY] = (st_q != ST_IDLE);
		stat_w[STA_AVAIL_LSB +: 8] = avail_q;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= apb_acc;
			pslverr_q <= apb_acc & ~hit_ctrl & ~hit_stat;
			if (apb_acc) begin
				prdata_q <= hit_ctrl ? {25'h0000000, ctrl_q} : (hit_stat ? stat_w : 32'h00000000);
			end
		end
	end

	// control register steers the machine; sticky status set wins over clear
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= CTRL_RST;
			sta_done_q <= 1'b0;
			sta_abort_q <= 1'b0;
			sta_coll_q <= 1'b0;
		end else begin
			if (apb_wr && hit_ctrl) begin
				ctrl_q <= pwdata[CTL_W-1:0];
			end
			sta_done_q <= done_q | (sta_done_q & ~(apb_wr & hit_stat & pwdata[STA_DONE]));
			sta_abort_q <= abort_q | (sta_abort_q & ~(apb_wr & hit_stat & pwdata[STA_ABORT]));
			sta_coll_q <= coll_q | (sta_coll_q & ~(apb_wr & hit_stat & pwdata[STA_COLL]));
		end
	end

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_preamble_first: assert property ($rose(tx_en_q) |-> txd_q == PRE_NIB)
		else $error("frame did not open with preamble nibble");
	a_sfd_after_pre: assert property (st_q == ST_PRE && tx_edge && nib_q == PRE_LAST && !coll_now
		|=> txd_q == SFD_NIB && st_q == ST_DATA)
		else $error("delimiter nibble missing after preamble");
	a_pad_zero: assert property (st_q == ST_PAD && $past(st_q == ST_PAD && tx_edge) |-> txd_q == 4'h0)
		else $error("pad nibble not zero");
	a_start_gate: assert property ($rose(tx_en_q) |-> $past(ctrl_q[CTL_TXEN] && !halted && gap_ok))
		else $error("frame started while disabled, halted or inside gap");
	a_retain_limit: assert property (!released_q |-> occ_q <= RETAIN_BYTES)
		else $error("more than retained bytes accepted before release");
	a_gap_restart: assert property (tx_edge && !tx_en_q && !fdx && !own_q && crs_s2_q
		&& gap_q < GAP_HOLD_NIBS |=> gap_q == 5'h00)
		else $error("early traffic did not restart the gap");
	a_gap_continue: assert property (tx_edge && !tx_en_q && gap_q >= GAP_HOLD_NIBS && !gap_ok
		|=> gap_q == $past(gap_q) + 5'h01)
		else $error("gap stalled in its last third");
	a_fdx_gap: assert property ($fell(tx_en_q) && fdx |-> gap_q == 5'h00)
		else $error("full duplex gap not started at own end");
	a_jam_ones: assert property (st_q == ST_JAM && tx_en_q |-> txd_q == JAM_NIB)
		else $error("jam nibble not all ones");
	a_coll_limit: assert property (att_q <= MAX_COLL)
		else $error("attempt count beyond the collision limit");
	a_start_bytes: assert property ($rose(tx_en_q) |-> $past(avail_q >= START_BYTES || tail_last_q))
		else $error("frame started without enough queued bytes");

	c_frame_done: cover property (st_q == ST_FCS ##1 st_q == ST_IDLE && done_q);
	c_padded: cover property (st_q == ST_PAD && tx_edge);
	c_backoff: cover property (st_q == ST_JAM ##1 st_q == ST_BACKOFF);
	c_discard: cover property (st_q == ST_DISCARD);
endmodule

// File: rtl/etx_pkg.sv
package etx_pkg;
	// How it works
	// - every frame opens with seven preamble bytes 10101010, sent left to right
	// - one delimiter byte 10101011 follows the preamble directly
	// - length/type above 1500 is a type; field goes out high byte first
	// - data shorter than 46 bytes is filled with zero pad bytes
	// - a 32-bit Ethernet CRC over address through data is appended last
	// - start only with transmit enabled and all three halt bits clear
	// - hold the first 64 frame bytes until the medium is acquired
	// - half duplex gap counts 96 bits; traffic in first 64 restarts it
	// - traffic in the last third of the gap does not restart it
	// - after own transmission the gap completes in 96 bits regardless of traffic
	// - full duplex gap starts at own transmission end, ignores traffic
	// - after a collision wait a whole number of 512-bit slots, maybe zero
	// - slots drawn from low min(retries,10) bits of an 11-bit random generator
	// - preamble starts only with data queued, gap valid and MII ready
	// - pad to 64 frame bytes unless short mode; CRC only when enabled
	// - collision in first 72 byte times: stop, jam 32 ones, back off, retry
	// - after 60 clean bytes release the retained frame start to the DMA
	// - parity error, FIFO error or over 16 collisions abandon the frame
	// - FIFO filled on system clock, drained at the sampled transmit clock pace; discard drains on the system clock
	// - start needs transmit enable and eight bytes queued (or a shorter frame's last byte), in either order
	// - the transmit FIFO is empty right after reset

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam int CTL_TXEN = 0;
	localparam int CTL_TXHALT = 1;
	localparam int CTL_HALTIMM = 2;
	localparam int CTL_HALTREQ = 3;
	localparam int CTL_FDX = 4;
	localparam int CTL_SHORT = 5;
	localparam int CTL_CRCEN = 6;
	localparam int CTL_W = 7;
	localparam logic [6:0] CTRL_RST = 7'h40;
	localparam int STA_DONE = 0;
	localparam int STA_ABORT = 1;
	localparam int STA_COLL = 2;
	localparam int STA_ATT_LSB = 8;
	localparam int STA_BUSY = 15;
	localparam int STA_AVAIL_LSB = 16;

	localparam int BITS_PER_NIB = 4;
	localparam int GAP_BITS = 96;
	localparam int GAP_HOLD_BITS = 64;
	localparam int SLOT_BITS = 512;
	localparam int JAM_BITS = 32;
	localparam int WIN_BYTES = 72;
	localparam int PRE_BYTES = 7;
	localparam logic [4:0] GAP_NIBS = 5'(GAP_BITS / BITS_PER_NIB);
	localparam logic [4:0] GAP_HOLD_NIBS = 5'(GAP_HOLD_BITS / BITS_PER_NIB);
	localparam logic [16:0] SLOT_NIBS = 17'(SLOT_BITS / BITS_PER_NIB);
	localparam logic [3:0] JAM_NIBS = 4'(JAM_BITS / BITS_PER_NIB);
	localparam logic [7:0] WIN_NIBS = 8'(WIN_BYTES * 2);
	localparam logic [3:0] PRE_LAST = 4'((PRE_BYTES + 1) * 2 - 1);
	localparam logic [3:0] FCS_LAST = 4'h7;
	localparam logic [3:0] PRE_NIB = 4'h5;
	localparam logic [3:0] SFD_NIB = 4'hD;
	localparam logic [3:0] JAM_NIB = 4'hF;
	localparam logic [3:0] IDLE_NIB = 4'h0;

	localparam logic [7:0] RETAIN_BYTES = 8'h40;
	localparam logic [11:0] RELEASE_BYTES = 12'h03C;
	localparam logic [7:0] START_BYTES = 8'h08;
	localparam logic [11:0] MIN_FRAME = 12'h040;
	localparam logic [11:0] CRC_BYTES = 12'h004;
	localparam logic [4:0] MAX_COLL = 5'h10;
	localparam logic [4:0] BACKOFF_LIMIT = 5'h0A;
	localparam logic [10:0] LFSR_SEED = 11'h001;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam int LAST_BIT = 8;
	localparam int PAR_BIT = 9;

	typedef enum logic [2:0] {
		ST_IDLE, ST_PRE, ST_DATA, ST_PAD, ST_FCS, ST_JAM, ST_BACKOFF, ST_DISCARD
	} etx_state_t;
endpackage

// File: testbench/etx_phy_model.sv
`timescale 1ns/1ps
module etx_phy_model (
	// mii towards the mac
	output logic mii_tx_clk,
	output logic mii_crs,
	output logic mii_col,
	input wire logic [3:0] mii_txd,
	input wire logic mii_tx_en
);
	logic [3:0] cur[$];
	logic [3:0] last[$];
	int bursts = 0;
	int idle = 0;
	int gap = 0;
	logic col_arm = 1'b0;
	// foreign carrier, raised only by a test
	logic crs_ext = 1'b0;

	// free-running transmit clock, phase unrelated to the system clock
	initial begin
		mii_tx_clk = 1'b0;
		mii_col = 1'b0;
		#7;
		forever #160 mii_tx_clk = ~mii_tx_clk;
	end

	// own transmission and a collision both show as carrier
	assign mii_crs = mii_tx_en | mii_col | crs_ext;

	// nibbles taken at each transmit clock rise
	always @(posedge mii_tx_clk) begin
		if (mii_tx_en === 1'b1) begin
			if (cur.size() == 0)
				gap = idle;
			// collision is only raised when a test arms it
			if (col_arm && cur.size() == 5) begin
				mii_col <= 1'b1;
				col_arm <= 1'b0;
			end
			cur.push_back(mii_txd);
			idle = 0;
		end else begin
			if (cur.size() != 0) begin
				last = cur;
				cur.delete();
				bursts++;
			end
			idle++;
			mii_col <= 1'b0;
		end
	end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top import etx_pkg::*;;
	typedef logic [7:0] etx_bq_t[$];
	localparam int LIM = 20000;
	logic mclk = 1'b0;
	logic reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, dma_data;
	logic [31:0] pwdata, prdata;
	logic dma_par, dma_last, dma_valid, dma_ready;
	logic mii_tx_clk, mii_crs, mii_col, mii_tx_en;
	logic [3:0] mii_txd;
	int miscompares = 0;
	int total_checks = 0;

	always #20 mclk = ~mclk;

	etx_mac_tx #(.FIFO_DEPTH(80)) dut (
		.mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dma_data(dma_data), .dma_par(dma_par), .dma_last(dma_last),
		.dma_valid(dma_valid), .dma_ready(dma_ready), .mii_tx_clk(mii_tx_clk),
		.mii_crs(mii_crs), .mii_col(mii_col), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en)
	);

	etx_phy_model phy (
		.mii_tx_clk(mii_tx_clk), .mii_crs(mii_crs), .mii_col(mii_col),
		.mii_txd(mii_txd), .mii_tx_en(mii_tx_en)
	);

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= LIM) begin
			miscompares++;
			$display("[FAIL] %0t wait ran out", $time);
			close_out();
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < LIM);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tmo(n);
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic push(input etx_bq_t f, input int bad);
		int n;
		foreach (f[i]) begin
			dma_data <= f[i];
			dma_par <= ~^f[i] ^ (i == bad);
			dma_last <= (i == f.size() - 1);
			dma_valid <= 1'b1;
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (dma_ready !== 1'b1 && n < LIM);
			tmo(n);
		end
		dma_valid <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wait_b(input int k);
		int n;
		n = 0;
		while (phy.bursts < k && n < LIM) begin
			@(posedge mclk);
			n++;
		end
		tmo(n);
	endtask

	// bytes 12 and 13 carry the length, high byte first
	function automatic etx_bq_t mkf(input int n, input logic [7:0] s);
		etx_bq_t q;
		for (int i = 0; i < n; i++)
			q.push_back(i == 12 ? 8'h00 : i == 13 ? 8'(n - 14) : 8'(s + 8'(i * 3)));
		return q;
	endfunction

	task automatic chk_frame(input etx_bq_t f, input logic [31:0] c);
		etx_bq_t e;
		logic [31:0] crc;
		e = f;
		while (!c[CTL_SHORT] && e.size() < (c[CTL_CRCEN] ? 60 : 64))
			e.push_back(8'h00);
		if (c[CTL_CRCEN]) begin
			crc = CRC_INIT;
			foreach (e[i]) begin
				crc ^= 32'(e[i]);
				repeat (8) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
			end
			for (int k = 0; k < 4; k++)
				e.push_back(~crc[8 * k +: 8]);
		end
		chk(32'(phy.last.size()), 32'(16 + 2 * e.size()), "frame nibbles");
		for (int i = 0; i < 16; i++)
			chk(32'(phy.last[i]), 32'(i == 15 ? SFD_NIB : PRE_NIB), "preamble");
		foreach (e[i])
			chk({phy.last[17 + 2 * i], phy.last[16 + 2 * i]}, 32'(e[i]), "byte");
	endtask

	task automatic t_reset();
		logic [31:0] r;
		logic e;
		chk(32'(dma_ready), 32'h1, "ready after reset");
		chk(32'(mii_tx_en), 32'h0, "line idle");
		apb(1'b0, REG_CTRL, 32'h0, r, e);
		chk(r, 32'(CTRL_RST), "ctrl reset value");
		apb(1'b0, REG_STAT, 32'h0, r, e);
		chk(32'(r[23:16]), 32'h0, "fifo empty");
		apb(1'b0, 8'h08, 32'h0, r, e);
		chk(32'(e), 32'h1, "unmapped error");
		$display("test reset done, mismatches %0d", miscompares);
	endtask

	task automatic t_modes();
		logic [31:0] c[3];
		int h[3];
		etx_bq_t f;
		int b;
		c = '{32'h41, 32'h01, 32'h21};
		h = '{CTL_TXHALT, CTL_HALTIMM, CTL_HALTREQ};
		f = mkf(20, 8'h10);
		push(f, -1);
		b = phy.bursts;
		foreach (h[i]) begin
			wr(REG_CTRL, 32'h41 | (32'h1 << h[i]));
			repeat (400) @(posedge mclk);
			chk(32'(phy.bursts), 32'(b), "halted start");
		end
		foreach (c[i]) begin
			wr(REG_CTRL, c[i]);
			if (i > 0)
				push(f, -1);
			wait_b(b + i + 1);
			chk_frame(f, c[i]);
		end
		$display("test modes done, mismatches %0d", miscompares);
	endtask

	task automatic t_coll();
		etx_bq_t f;
		logic [31:0] r;
		logic e;
		int b;
		f = mkf(30, 8'h40);
		b = phy.bursts;
		phy.col_arm = 1'b1;
		wr(REG_CTRL, 32'h41);
		push(f, -1);
		wait_b(b + 1);
		for (int i = 1; i <= 8; i++)
			chk(32'(phy.last[phy.last.size() - i]), 32'(JAM_NIB), "jam");
		chk(32'(phy.last.size() < 40), 32'h1, "cut short");
		wait_b(b + 2);
		chk_frame(f, 32'h41);
		apb(1'b0, REG_STAT, 32'h0, r, e);
		chk(32'(r[STA_COLL]), 32'h1, "collision flag");
		$display("test collision done, mismatches %0d", miscompares);
	endtask

	task automatic t_fdx();
		etx_bq_t f;
		etx_bq_t g;
		int b;
		f = mkf(24, 8'h70);
		g = mkf(24, 8'h90);
		b = phy.bursts;
		wr(REG_CTRL, 32'h51);
		push(f, -1);
		push(g, -1);
		wait_b(b + 2);
		chk(32'(phy.gap >= GAP_NIBS && phy.gap <= GAP_NIBS + 4), 32'h1, "gap");
		chk_frame(g, 32'h51);
		$display("test full duplex done, mismatches %0d", miscompares);
	endtask

	task automatic t_par();
		etx_bq_t f;
		etx_bq_t g;
		logic [31:0] r;
		logic e;
		int b;
		f = mkf(20, 8'h22);
		g = mkf(22, 8'h33);
		b = phy.bursts;
		wr(REG_CTRL, 32'h41);
		push(f, 3);
		push(g, -1);
		wait_b(b + 1);
		if (phy.last.size() != 144)
			wait_b(b + 2);
		chk_frame(g, 32'h41);
		apb(1'b0, REG_STAT, 32'h0, r, e);
		chk(32'(r[STA_ABORT]), 32'h1, "abort flag");
		$display("test parity done, mismatches %0d", miscompares);
	endtask

	// half duplex deferral: carrier holds the gap, late carrier does not restart it
	task automatic t_defer();
		etx_bq_t f;
		int b;
		f = mkf(16, 8'h55);
		b = phy.bursts;
		repeat (400) @(posedge mclk);
		phy.crs_ext <= 1'b1;
		push(f, -1);
		repeat (600) @(posedge mclk);
		chk(32'(phy.bursts), 32'(b), "start during carrier");
		phy.crs_ext <= 1'b0;
		repeat (150) @(posedge mclk);
		chk(32'(mii_tx_en), 32'h0, "gap after carrier");
		phy.crs_ext <= 1'b1;
		repeat (16) @(posedge mclk);
		phy.crs_ext <= 1'b0;
		repeat (94) @(posedge mclk);
		chk(32'(mii_tx_en), 32'h1, "late carrier ignored");
		wait_b(b + 1);
		chk_frame(f, 32'h41);
		$display("test defer done, mismatches %0d", miscompares);
	endtask

	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		dma_data = 8'h00;
		dma_par = 1'b0;
		dma_last = 1'b0;
		dma_valid = 1'b0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_reset();
		t_modes();
		t_coll();
		t_fdx();
		t_par();
		t_defer();
		close_out();
	end
endmodule
